// [logic/pud_map.svh]
`ifndef PUD_MAP_SVH
`define PUD_MAP_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PUD_OFS_CTRL 12'h000
`define PUD_OFS_DIM 12'h004
`define PUD_OFS_ADDR 12'h008
`define PUD_OFS_DATA 12'h00c
`define PUD_OFS_FPHK 12'h010
`define PUD_OFS_RCHK 12'h014
`define PUD_OFS_STAT 12'h018
`define PUD_OFS_IRQ 12'h01c
`define PUD_OFS_MASK 12'h020
`define PUD_OFS_SEG 12'h024
// ----------------------------------------
// ctrl field positions
// ----------------------------------------
`define PUD_CTRL_DISP_ON 0
`define PUD_CTRL_SCAN_ON 1
`define PUD_CTRL_IR_EN 2
`define PUD_CTRL_RC_EN 3
`define PUD_CTRL_MODE_LO 4
`define PUD_CTRL_MODE_HI 5
`define PUD_CTRL_RTC_SB 6
`define PUD_CTRL_STBY 7
// ----------------------------------------
// reset values
// ----------------------------------------
`define PUD_CTRL_RST 8'h02
`define PUD_MODE_8SEG_1DIG 2'h0
`define PUD_DIM_RST 4'h9
`define PUD_ADDR_FIRST 5'h10
`define PUD_ADDR_LAST 5'h14
`define PUD_GUARD_S 10
`define PUD_CLK_HZ 100000000
`define PUD_GUARD_CYC (64'd10 * 64'd100000000)
`define PUD_POR_CYC 4
`endif

// [logic/pud_pkg.sv]
package pud_pkg;
  typedef enum logic [2:0] {
    PUD_POR = 3'b001,
    PUD_RUN = 3'b010,
    PUD_SBY = 3'b100
  } pud_state_t;
  typedef logic [7:0] pud_seg_t;
endpackage : pud_pkg

// [logic/pud_mem_if.sv]
`timescale 1ns/100ps
interface pud_mem_if;
  logic we;
  logic [2:0] waddr;
  logic [7:0] wdata;
  logic [2:0] raddr;
  logic [7:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : pud_mem_if

// [logic/pud_disp_mem.sv]
`timescale 1ns/100ps
module pud_disp_mem #(
  parameter int DEPTH = 5
) (
  input wire aclk,
  input wire aresetn,
  pud_mem_if.mem m
);
  logic [7:0] mem_ff [DEPTH];
  logic [7:0] rd_ff;
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_loc
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          mem_ff[g] <= 8'h00;
        end else if (m.we && m.waddr == 3'(g)) begin
          mem_ff[g] <= m.wdata;
        end
      end
    end
  endgenerate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_ff <= 8'h00;
    end else if (int'(m.raddr) < DEPTH) begin
      rd_ff <= mem_ff[m.raddr];
    end
  end
  assign m.rdata = rd_ff;
endmodule : pud_disp_mem

// [logic/pud_top.sv]
// Operation
// - reset starts display off, scan on, infrared and protocol off, mode 0, guard 10 s
// - display pointer starts at 10h with auto increment after each byte
// - dimming starts at ten sixteenths until software changes it
// - display drives the pattern stored in display memory, kept across standby
// - displayed pattern changes only by software commands or memory writes; standby clock follows rtc_pattern, hot-key wake ends it
// - standby shows clock value only when software enabled it
// - all hot keys disabled after reset until software configures them
// - in standby only configured hot key matches cause wake-up
// - auto increment wraps pointer from 14h back to 10h
// - dimming code 1001 means ten sixteenths, equals reset value
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "pud_map.svh"
module pud_top #(
  parameter longint GUARD_CYC = `PUD_GUARD_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output logic s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] front_panel_keys,
  input wire [15:0] remote_control_code,
  input wire remote_control_valid,
  input wire [7:0] rtc_pattern,
  output logic [7:0] seg_out,
  output logic [2:0] digit_sel,
  output logic [3:0] dim_duty,
  output logic stby_out,
  output logic irq
);
  // ----------------------------------------
  // power-on sequence
  // ----------------------------------------
  pud_pkg::pud_state_t st_ff;
  pud_pkg::pud_state_t nxt_st;
  logic [2:0] por_cnt_ff;
  logic wake;
  logic sby_cmd;
  logic run_cmd;
  // bus held off until defaults loaded
  always_comb begin
    case (st_ff)
      pud_pkg::PUD_POR: nxt_st = (por_cnt_ff == 3'(`PUD_POR_CYC - 1)) ? pud_pkg::PUD_RUN : st_ff;
      pud_pkg::PUD_RUN: nxt_st = sby_cmd ? pud_pkg::PUD_SBY : st_ff;
      pud_pkg::PUD_SBY: nxt_st = (wake || run_cmd) ? pud_pkg::PUD_RUN : st_ff;
      default: nxt_st = pud_pkg::PUD_POR;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= pud_pkg::PUD_POR;
      por_cnt_ff <= 3'h0;
    end else begin
      st_ff <= nxt_st;
      por_cnt_ff <= (st_ff == pud_pkg::PUD_POR) ? por_cnt_ff + 3'h1 : 3'h0;
    end
  end
  wire ready_st = (st_ff != pud_pkg::PUD_POR);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] fp_s1_ff, fp_s2_ff;
  logic [15:0] rc_s1_ff, rc_s2_ff;
  logic rcv_s1_ff, rcv_s2_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fp_s1_ff <= 4'h0;
      fp_s2_ff <= 4'h0;
      rc_s1_ff <= 16'h0000;
      rc_s2_ff <= 16'h0000;
      rcv_s1_ff <= 1'b0;
      rcv_s2_ff <= 1'b0;
    end else begin
      fp_s1_ff <= front_panel_keys;
      fp_s2_ff <= fp_s1_ff;
      rc_s1_ff <= remote_control_code;
      rc_s2_ff <= rc_s1_ff;
      rcv_s1_ff <= remote_control_valid;
      rcv_s2_ff <= rcv_s1_ff;
    end
  end
  // ----------------------------------------
  // axi-lite handshake
  // ----------------------------------------
  logic aw_ok_ff, w_ok_ff, bvalid_ff, rvalid_ff, arready_ff, awready_ff, wready_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [1:0] bresp_ff, rresp_ff;
  wire do_wr = aw_ok_ff && w_ok_ff && !bvalid_ff;
  // ready is a one-cycle registered pulse; the item moves at the next edge, valid still up
  wire aw_take = s_axi_awvalid && !awready_ff && !aw_ok_ff && !bvalid_ff && ready_st;
  wire w_take = s_axi_wvalid && !wready_ff && !w_ok_ff && !bvalid_ff && ready_st;
  wire ar_take = s_axi_arvalid && !rvalid_ff && !arready_ff && ready_st;
  wire aw_hs = s_axi_awvalid && awready_ff;
  wire w_hs = s_axi_wvalid && wready_ff;
  wire ar_hs = s_axi_arvalid && arready_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0000_0000;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end else begin
      awready_ff <= aw_take;
      wready_ff <= w_take;
      if (aw_hs) begin
        aw_ok_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_ok_ff <= 1'b0;
      end
      if (w_hs) begin
        w_ok_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end else if (do_wr) begin
        w_ok_ff <= 1'b0;
      end
      if (do_wr) begin
        bvalid_ff <= 1'b1;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // write decode
  // ----------------------------------------
  wire [9:0] widx = awaddr_ff[11:2];
  wire wr_ctrl = do_wr && widx == 10'(`PUD_OFS_CTRL >> 2);
  wire wr_dim = do_wr && widx == 10'(`PUD_OFS_DIM >> 2);
  wire wr_addr = do_wr && widx == 10'(`PUD_OFS_ADDR >> 2);
  wire wr_data = do_wr && widx == 10'(`PUD_OFS_DATA >> 2);
  wire wr_fphk = do_wr && widx == 10'(`PUD_OFS_FPHK >> 2);
  wire wr_rchk = do_wr && widx == 10'(`PUD_OFS_RCHK >> 2);
  wire wr_irq = do_wr && widx == 10'(`PUD_OFS_IRQ >> 2);
  wire wr_mask = do_wr && widx == 10'(`PUD_OFS_MASK >> 2);
  wire wr_ok = do_wr && widx <= 10'(`PUD_OFS_SEG >> 2);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_ff <= 2'h0;
    end else if (do_wr) begin
      bresp_ff <= wr_ok ? 2'h0 : 2'h2;
    end
  end
  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [7:0] ctrl_ff;
  logic [3:0] dim_ff;
  logic [4:0] ptr_ff;
  logic [15:0] fphk_ff;
  logic [15:0] rchk_ff;
  logic rchk_en_ff;
  logic [1:0] irq_st_ff, mask_ff;
  logic [63:0] guard_ff;
  assign sby_cmd = wr_ctrl && wdata_ff[`PUD_CTRL_STBY];
  assign run_cmd = wr_ctrl && !wdata_ff[`PUD_CTRL_STBY];
  wire [4:0] ptr_inc = (ptr_ff == `PUD_ADDR_LAST) ? `PUD_ADDR_FIRST : ptr_ff + 5'h1;
  wire addr_ok = wdata_ff[4:0] >= `PUD_ADDR_FIRST && wdata_ff[4:0] <= `PUD_ADDR_LAST;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `PUD_CTRL_RST;
      dim_ff <= `PUD_DIM_RST;
      ptr_ff <= `PUD_ADDR_FIRST;
      fphk_ff <= 16'h0000;
      rchk_ff <= 16'h0000;
      rchk_en_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= {1'b0, wdata_ff[6:0]};
      end
      if (wr_dim) begin
        dim_ff <= wdata_ff[3:0];
      end
      if (wr_addr && addr_ok) begin
        ptr_ff <= wdata_ff[4:0];
      end else if (wr_data) begin
        ptr_ff <= ptr_inc;
      end
      if (wr_fphk) begin
        fphk_ff <= wdata_ff[15:0];
      end
      if (wr_rchk) begin
        rchk_ff <= wdata_ff[15:0];
        rchk_en_ff <= wdata_ff[16];
      end
    end
  end
  // guard timer loaded with 10 s
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      guard_ff <= 64'(GUARD_CYC);
    end else if (st_ff == pud_pkg::PUD_SBY && guard_ff != 64'h0) begin
      guard_ff <= guard_ff - 64'h1;
    end else if (st_ff != pud_pkg::PUD_SBY) begin
      guard_ff <= 64'(GUARD_CYC);
    end
  end
  // ----------------------------------------
  // hot-key wake detection
  // ----------------------------------------
  // key code = bank bit plus 3-bit key index, one-hot into 16 enables
  wire [15:0] fp_hot = 16'h0001 << fp_s2_ff;
  // code 0 is no key, so it never wakes even with enable bit 0 set
  wire fp_press = fp_s2_ff != 4'h0;
  wire fp_match = fp_press && ((fp_hot & fphk_ff) != 16'h0000);
  wire rc_match = rcv_s2_ff && rchk_en_ff && rc_s2_ff == rchk_ff && ctrl_ff[`PUD_CTRL_IR_EN];
  assign wake = (st_ff == pud_pkg::PUD_SBY) && (fp_match || rc_match) && guard_ff == 64'h0;
  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  wire [1:0] ev = {fp_match && wake, rc_match && wake};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_ff <= 2'h0;
      mask_ff <= 2'h0;
      irq <= 1'b0;
    end else begin
      irq_st_ff <= ev | (irq_st_ff & ~(wr_irq ? wdata_ff[1:0] : 2'h0));
      if (wr_mask) begin
        mask_ff <= wdata_ff[1:0];
      end
      irq <= ((ev | (irq_st_ff & ~(wr_irq ? wdata_ff[1:0] : 2'h0))) & mask_ff) != 2'h0;
    end
  end
  // ----------------------------------------
  // display memory and scan
  // ----------------------------------------
  pud_mem_if mif ();
  logic [2:0] dig_ff;
  assign mif.we = wr_data;
  assign mif.waddr = 3'(ptr_ff - `PUD_ADDR_FIRST);
  assign mif.wdata = wdata_ff[7:0];
  assign mif.raddr = dig_ff;
  pud_disp_mem #(.DEPTH(5)) pud_disp_mem_inst (.aclk(aclk), .aresetn(aresetn), .m(mif));
  wire show_rtc = (st_ff == pud_pkg::PUD_SBY) && ctrl_ff[`PUD_CTRL_RTC_SB];
  logic [2:0] dig_d_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dig_ff <= 3'h0;
      dig_d_ff <= 3'h0;
      seg_out <= 8'h00;
      digit_sel <= 3'h0;
      dim_duty <= `PUD_DIM_RST;
      stby_out <= 1'b0;
    end else begin
      dig_ff <= (dig_ff == 3'h4) ? 3'h0 : dig_ff + 3'h1;
      dig_d_ff <= dig_ff;
      seg_out <= !ctrl_ff[`PUD_CTRL_DISP_ON] ? 8'h00 : show_rtc ? rtc_pattern : mif.rdata;
      digit_sel <= dig_d_ff;
      dim_duty <= dim_ff;
      stby_out <= (nxt_st == pud_pkg::PUD_SBY);
    end
  end
  // ----------------------------------------
  // read path
  // ----------------------------------------
  wire [9:0] ridx = s_axi_araddr[11:2];
  wire [31:0] rd_mux =
    (ridx == 10'(`PUD_OFS_CTRL >> 2)) ? {24'h0, ctrl_ff} :
    (ridx == 10'(`PUD_OFS_DIM >> 2)) ? {28'h0, dim_ff} :
    (ridx == 10'(`PUD_OFS_ADDR >> 2)) ? {27'h0, ptr_ff} :
    (ridx == 10'(`PUD_OFS_FPHK >> 2)) ? {16'h0, fphk_ff} :
    (ridx == 10'(`PUD_OFS_RCHK >> 2)) ? {15'h0, rchk_en_ff, rchk_ff} :
    (ridx == 10'(`PUD_OFS_STAT >> 2)) ? {29'h0, st_ff} :
    (ridx == 10'(`PUD_OFS_IRQ >> 2)) ? {30'h0, irq_st_ff} :
    (ridx == 10'(`PUD_OFS_MASK >> 2)) ? {30'h0, mask_ff} :
    (ridx == 10'(`PUD_OFS_SEG >> 2)) ? {24'h0, seg_out} : 32'h0;
  wire rd_ok = ridx <= 10'(`PUD_OFS_SEG >> 2) && ridx != 10'(`PUD_OFS_DATA >> 2);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= 2'h0;
    end else begin
      arready_ff <= ar_take;
      if (ar_hs) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_dim_default: assert property (@(posedge aclk) $rose(aresetn) |-> dim_ff == 4'h9)
    else $error("dim default wrong");
  a_ptr_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_data && ptr_ff == 5'h14 && !wr_addr) |=> ptr_ff == 5'h10) else $error("no wrap");
  a_hk_reset: assert property (@(posedge aclk) $rose(aresetn) |-> fphk_ff == 16'h0)
    else $error("hot keys on");
  a_ctrl_def: assert property (@(posedge aclk) $rose(aresetn) |-> ctrl_ff == 8'h02)
    else $error("ctrl default");
  a_por_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff == pud_pkg::PUD_POR |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("bus early");
  a_ptr_start: assert property (@(posedge aclk) $rose(aresetn) |-> ptr_ff == 5'h10)
    else $error("ptr default");
  a_wake_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(stby_out) |-> $past(fp_match || rc_match || run_cmd)) else $error("bad wake");
  a_seg_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    (!wr_data && !wr_ctrl && !show_rtc) [*8] |=> seg_out == $past(seg_out, 5))
    else $error("seg moved");
  c_sby: cover property (@(posedge aclk) st_ff == pud_pkg::PUD_SBY);
  c_wake: cover property (@(posedge aclk) wake);
  c_wrap: cover property (@(posedge aclk) wr_data && ptr_ff == 5'h14);
endmodule : pud_top

// [dv/pud_host.sv]
`timescale 1ns/100ps
// ----------------------------------------
// host side: register bus master
// ----------------------------------------
module pud_host (
  input wire aclk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // message written before standby is the caller's order of calls
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : pud_host

// [dv/power_up_default_state_bench.sv]
`timescale 1ns/100ps
`include "pud_map.svh"
module power_up_default_state_bench;
  logic aclk, aresetn, arv, rv, awr, wr_rdy, bv, arr;
  logic [11:0] awa, ara;
  logic awv, wv, br, rr;
  logic [31:0] wd, rdt, got;
  logic [3:0] ws, fpk, dim;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] seg, rtc;
  logic [2:0] dsel;
  logic stby, irq;
  logic [15:0] rcc;
  logic rcv;
  int failures = 0;
  int compares = 0;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} pud_row_t;
  pud_row_t rows[4] = '{'{12'h004, 32'h0000_0005, 32'h0000_0005},
                        '{12'h004, 32'h0000_0009, 32'h0000_0009},
                        '{12'h000, 32'h0000_0001, 32'h0000_0001},
                        '{12'h010, 32'h0000_0008, 32'h0000_0008}};
  pud_top #(.GUARD_CYC(10)) pud_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .front_panel_keys(fpk), .remote_control_code(rcc),
    .remote_control_valid(rcv), .rtc_pattern(rtc), .seg_out(seg), .digit_sel(dsel),
    .dim_duty(dim), .stby_out(stby), .irq(irq));
  pud_host pud_host_inst (.aclk(aclk), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg
  task automatic chk_bit(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit
  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // margin past the internal power-on count
    repeat (`PUD_POR_CYC + 2) @(posedge aclk);
  endtask : do_reset
  task automatic chk_defaults;
    chk_reg("dim_duty pin", 32'h9, {28'h0, dim});
    pud_host_inst.rd(12'h000, got, resp);
    chk_reg("ctrl", 32'h0000_0002, got);
    pud_host_inst.rd(12'h004, got, resp);
    chk_reg("dim", 32'h0000_0009, got);
    pud_host_inst.rd(12'h008, got, resp);
    chk_reg("addr", 32'h0000_0010, got);
    pud_host_inst.rd(12'h010, got, resp);
    chk_reg("fphk", 32'h0000_0000, got);
    pud_host_inst.rd(12'h014, got, resp);
    chk_reg("rchk", 32'h0000_0000, got);
    chk_bit("stby_out", 1'b0, stby);
  endtask : chk_defaults
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    conclude();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    aresetn = 1'b0;
    fpk = 4'h0;
    rcc = 16'h0000;
    rcv = 1'b0;
    rtc = 8'ha5;
    do_reset();
    chk_defaults();
    $display("test defaults done");
    foreach (rows[i]) begin
      pud_host_inst.wr(rows[i].a, rows[i].d, resp);
      pud_host_inst.rd(rows[i].a, got, resp);
      chk_reg("row readback", rows[i].e, got);
    end
    chk_reg("dim_duty pin", 32'h9, {28'h0, dim});
    $display("test table done");
    pud_host_inst.wr(12'h03c, 32'h0000_0001, resp);
    chk_reg("unmapped bresp", 32'h2, {30'h0, resp});
    $display("test unmapped done");
    // five display slots, so after six bytes the pointer is back on the second slot
    pud_host_inst.wr(12'h008, 32'h0000_0010, resp);
    for (int i = 0; i < 6; i++) pud_host_inst.wr(12'h00c, 32'h11 + i, resp);
    pud_host_inst.rd(12'h008, got, resp);
    chk_reg("addr wrap", 32'h0000_0011, got);
    $display("test wrap done");
    pud_host_inst.wr(12'h020, 32'h0000_0003, resp);
    pud_host_inst.wr(12'h000, 32'h0000_00c3, resp);
    repeat (50) @(posedge aclk);
    chk_reg("seg in standby with clock", 32'ha5, {24'h0, seg});
    pud_host_inst.wr(12'h000, 32'h0000_0083, resp);
    repeat (5) @(posedge aclk);
    // slot 0 holds the sixth byte after the wrap, the others the first pass
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      got = (dsel == 3'h0) ? 32'h16 : 32'h11 + dsel;
      chk_reg("seg shows memory", got, {24'h0, seg});
    end
    $display("test standby display done");
    fpk <= 4'h5;
    repeat (12) @(posedge aclk);
    chk_bit("stby_out other key", 1'b1, stby);
    fpk <= 4'h3;
    repeat (12) @(posedge aclk);
    fpk <= 4'h0;
    chk_bit("stby_out hot key", 1'b0, stby);
    chk_bit("irq raised", 1'b1, irq);
    pud_host_inst.wr(12'h020, 32'h0000_0000, resp);
    repeat (2) @(posedge aclk);
    chk_bit("irq masked", 1'b0, irq);
    pud_host_inst.wr(12'h01c, 32'hffff_ffff, resp);
    pud_host_inst.rd(12'h01c, got, resp);
    chk_reg("irq status cleared", 32'h0, got);
    $display("test wake done");
    // remote wake: a wrong code must not wake, the configured one must
    pud_host_inst.wr(12'h014, 32'h0001_abcd, resp);
    pud_host_inst.wr(12'h000, 32'h0000_0087, resp);
    repeat (15) @(posedge aclk);
    rcc <= 16'h1234;
    rcv <= 1'b1;
    repeat (6) @(posedge aclk);
    chk_bit("stby_out other code", 1'b1, stby);
    rcc <= 16'habcd;
    repeat (6) @(posedge aclk);
    rcv <= 1'b0;
    chk_bit("stby_out remote hot key", 1'b0, stby);
    $display("test remote wake done");
    // second reset in mid-run must bring back the ctrl, dim, addr, hot-key and stby_out defaults
    do_reset();
    chk_defaults();
    $display("test second reset done");
    conclude();
  end
endmodule : power_up_default_state_bench
